//--- pkg/sar_pkg.sv
// Shared constants and carrier types for the SAR converter control block
`default_nettype none
package sar_pkg;
    // Register word byte offsets
    localparam logic [5:0] SAR_OFS_CTRL = 6'h00;
    localparam logic [5:0] SAR_OFS_MUX = 6'h04;
    localparam logic [5:0] SAR_OFS_TIMING = 6'h08;
    localparam logic [5:0] SAR_OFS_CMD = 6'h0C;
    localparam logic [5:0] SAR_OFS_STATUS = 6'h10;
    localparam logic [5:0] SAR_OFS_WINCTRL = 6'h14;
    localparam logic [5:0] SAR_OFS_WINLO = 6'h18;
    localparam logic [5:0] SAR_OFS_WINHI = 6'h1C;
    localparam logic [5:0] SAR_OFS_RESULT = 6'h20;
    // Control word field positions
    localparam int SAR_CTRL_ENABLE = 0;
    localparam int SAR_CTRL_DIFF = 1;
    localparam int SAR_CTRL_DEPTH10 = 2;
    localparam int SAR_CTRL_LEFT = 3;
    localparam int SAR_CTRL_CONT = 4;
    localparam int SAR_CTRL_EVEN = 5;
    localparam int SAR_CTRL_DIV = 8;
    localparam int SAR_CTRL_ACC = 12;
    localparam int SAR_CTRL_DONEIE = 16;
    localparam int SAR_CTRL_WINIE = 17;
    // Mux, timing, command and status field positions
    localparam int SAR_MUX_POS = 0;
    localparam int SAR_MUX_NEG = 8;
    localparam int SAR_TIM_LEN = 0;
    localparam int SAR_TIM_DLY = 8;
    localparam int SAR_CMD_START = 0;
    localparam int SAR_STAT_DONE = 0;
    localparam int SAR_STAT_WIN = 1;
    // Reset values
    localparam logic [31:0] SAR_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] SAR_WINHI_RST = 16'hFFFF;
    // Window compare modes
    localparam logic [2:0] SAR_WIN_OFF = 3'h0;
    localparam logic [2:0] SAR_WIN_BELOW = 3'h1;
    localparam logic [2:0] SAR_WIN_ABOVE = 3'h2;
    localparam logic [2:0] SAR_WIN_INSIDE = 3'h3;
    localparam logic [2:0] SAR_WIN_OUTSIDE = 3'h4;
    // Timing counts, in converter clock ticks or core cycles
    localparam logic [9:0] SAR_SAMPLE_BASE = 10'h002;
    localparam logic [3:0] SAR_CONV_TICKS = 4'hE;
    localparam logic [1:0] SAR_FORMAT_CYCLES = 2'h2;
    localparam logic [2:0] SAR_ACC_MAX_CODE = 3'h7;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
    } sar_avm_req_t;

    // Controls toward the analog front end
    typedef struct packed {
        logic sample;
        logic convert;
        logic conv_clk;
        logic diff;
        logic [5:0] pos;
        logic [5:0] neg;
    } sar_afe_t;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        SAR_IDLE = 5'b00001,
        SAR_START = 5'b00010,
        SAR_SAMPLE = 5'b00100,
        SAR_CONVERT = 5'b01000,
        SAR_FORMAT = 5'b10000
    } sar_state_t;
endpackage
`default_nettype wire

//--- rtl/sar_ctrl.sv
// SAR converter control: register slave, sequencer, accumulator, compare
// Operation
// - Output is 10 or 12 bits, selectable
// - Kind bit selects single-ended or differential
// - Start by software command or router event
// - Events start only while event enable set
// - Accumulate up to 128 samples per trigger
// - Output is single sample or the sum
// - Window compare flags below/above/inside/outside
// - Continuous bit selects free-running operation
// - Left-align bit left adjusts single-sample output only
// - Converter clock is prescaled peripheral clock
// - Positive and negative input selects route channels
// - Enable low means no conversions at all
// - Completion raises interrupt and output event
// - Programmable delay added to every sampling phase
// - Sampling phase length programmable
// - Start command reads 1 while converting
// - Done flag sets even with interrupt off
// - Accumulator cleared when conversion begins
// - Channel change waits for conversion end
`default_nettype none
module sar_ctrl (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Avalon-MM slave
    input wire sar_pkg::sar_avm_req_t avm_req_i,
    output logic [31:0] avm_readdata_o,
    output logic avm_waitrequest_o,
    // Event router and analog front end
    input wire logic start_event_i,
    input wire logic [11:0] afe_data_i,
    output sar_pkg::sar_afe_t afe_o,
    // Completion outputs
    output logic done_event_o,
    output logic irq_o
);
    import sar_pkg::*;

    // All block state
    typedef struct packed {
        sar_state_t state;
        logic wait_r;
        logic [31:0] rdata;
        logic enable;
        logic diff;
        logic depth10;
        logic left;
        logic cont;
        logic ev_en;
        logic [2:0] div_sel;
        logic [2:0] acc_code;
        logic done_ie;
        logic win_ie;
        logic [5:0] pos_sel;
        logic [5:0] neg_sel;
        logic [7:0] samp_len;
        logic [7:0] samp_dly;
        logic [2:0] win_mode;
        logic [15:0] win_lo;
        logic [15:0] win_hi;
        logic busy;
        logic done_flag;
        logic win_flag;
        logic [19:0] result;
        logic [19:0] acc;
        logic [7:0] samp_cnt;
        logic [8:0] clock_divider_select;
        logic [9:0] phase;
        logic [5:0] pos_act;
        logic [5:0] neg_act;
        logic diff_act;
        logic ev_d;
        logic done_evt;
        logic irq;
        logic cclk;
    } sar_st_t;

    sar_st_t st_r;
    sar_st_t st_nxt;

    // Prescaler division 2, 4 ... 256
    function automatic logic [8:0] div_of(input logic [2:0] sel);
        div_of = 9'h002 << sel;
    endfunction

    // Samples per trigger from count code
    function automatic logic [7:0] nsamp(input logic [2:0] code);
        nsamp = 8'h01 << code;
    endfunction

    // Window hit test on the finished sum, never the left-adjusted word
    function automatic logic win_hit(input logic [2:0] mode,
            input logic [19:0] v, input logic [15:0] lo,
            input logic [15:0] hi);
        logic below;
        logic above;
        below = v < {4'h0, lo};
        above = v > {4'h0, hi};
        unique case (mode)
            SAR_WIN_BELOW: win_hit = below;
            SAR_WIN_ABOVE: win_hit = above;
            SAR_WIN_INSIDE: win_hit = !below && !above;
            SAR_WIN_OUTSIDE: win_hit = below || above;
            default: win_hit = 1'b0;
        endcase
    endfunction

    // Helpers, each written on every pass of the next-state process
    logic req;
    logic wr_take;
    logic trig;
    logic tick;
    logic [11:0] sample;
    logic [19:0] sum;
    logic [19:0] fmt;
    logic [8:0] div;
    logic [9:0] samp_end;

    // Sequencer and register file next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.done_evt = 1'b0;
        req = avm_req_i.read || avm_req_i.write;
        div = div_of(st_r.div_sel);
        tick = (st_r.clock_divider_select == div - 9'h001);
        samp_end = SAR_SAMPLE_BASE + {2'h0, st_r.samp_len}
            + {2'h0, st_r.samp_dly};
        // 10-bit depth drops the two lowest bits
        sample = st_r.depth10 ? {2'h0, afe_data_i[11:2]}
            : afe_data_i;
        sum = st_r.acc + {8'h00, sample};
        fmt = sum;
        // Left adjust a single sample only, into the low 16 bits
        if (st_r.left && st_r.acc_code == 3'h0) begin
            fmt = st_r.depth10 ? {4'h0, sample[9:0], 6'h00}
                : {4'h0, sample, 4'h0};
        end

        // Bus: one wait cycle, then answer
        // Writes land on the edge where waitrequest is seen low
        st_nxt.wait_r = !(req && st_r.wait_r);
        wr_take = avm_req_i.write && !st_r.wait_r;
        // Read data captured on reads only, so it holds across writes
        if (avm_req_i.read && st_r.wait_r) begin
            unique case (avm_req_i.address)
                SAR_OFS_CTRL: st_nxt.rdata = {14'h0, st_r.win_ie,
                    st_r.done_ie, 1'b0, st_r.acc_code, 1'b0,
                    st_r.div_sel, 2'h0, st_r.ev_en, st_r.cont,
                    st_r.left, st_r.depth10, st_r.diff, st_r.enable};
                SAR_OFS_MUX: st_nxt.rdata = {18'h0, st_r.neg_sel,
                    2'h0, st_r.pos_sel};
                SAR_OFS_TIMING: st_nxt.rdata = {16'h0, st_r.samp_dly,
                    st_r.samp_len};
                SAR_OFS_CMD: st_nxt.rdata = {31'h0, st_r.busy};
                SAR_OFS_STATUS: st_nxt.rdata = {30'h0, st_r.win_flag,
                    st_r.done_flag};
                SAR_OFS_WINCTRL: st_nxt.rdata = {29'h0, st_r.win_mode};
                SAR_OFS_WINLO: st_nxt.rdata = {16'h0, st_r.win_lo};
                SAR_OFS_WINHI: st_nxt.rdata = {16'h0, st_r.win_hi};
                SAR_OFS_RESULT: st_nxt.rdata = {12'h0, st_r.result};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes; status flags clear by writing one
        // A completion further down overrides a same-cycle clear
        if (wr_take) begin
            unique case (avm_req_i.address)
                SAR_OFS_CTRL: begin
                    st_nxt.enable = avm_req_i.writedata[SAR_CTRL_ENABLE];
                    st_nxt.diff = avm_req_i.writedata[SAR_CTRL_DIFF];
                    st_nxt.depth10 = avm_req_i.writedata[SAR_CTRL_DEPTH10];
                    st_nxt.left = avm_req_i.writedata[SAR_CTRL_LEFT];
                    st_nxt.cont = avm_req_i.writedata[SAR_CTRL_CONT];
                    st_nxt.ev_en = avm_req_i.writedata[SAR_CTRL_EVEN];
                    st_nxt.div_sel =
                        avm_req_i.writedata[SAR_CTRL_DIV +: 3];
                    st_nxt.acc_code =
                        avm_req_i.writedata[SAR_CTRL_ACC +: 3];
                    st_nxt.done_ie = avm_req_i.writedata[SAR_CTRL_DONEIE];
                    st_nxt.win_ie = avm_req_i.writedata[SAR_CTRL_WINIE];
                end
                SAR_OFS_MUX: begin
                    st_nxt.pos_sel = avm_req_i.writedata[SAR_MUX_POS +: 6];
                    st_nxt.neg_sel = avm_req_i.writedata[SAR_MUX_NEG +: 6];
                end
                SAR_OFS_TIMING: begin
                    st_nxt.samp_len = avm_req_i.writedata[SAR_TIM_LEN +: 8];
                    st_nxt.samp_dly = avm_req_i.writedata[SAR_TIM_DLY +: 8];
                end
                SAR_OFS_STATUS: begin
                    if (avm_req_i.writedata[SAR_STAT_DONE]) begin
                        st_nxt.done_flag = 1'b0;
                    end
                    if (avm_req_i.writedata[SAR_STAT_WIN]) begin
                        st_nxt.win_flag = 1'b0;
                    end
                end
                SAR_OFS_WINCTRL: st_nxt.win_mode = avm_req_i.writedata[2:0];
                SAR_OFS_WINLO: st_nxt.win_lo = avm_req_i.writedata[15:0];
                SAR_OFS_WINHI: st_nxt.win_hi = avm_req_i.writedata[15:0];
                default: st_nxt.rdata = st_nxt.rdata;
            endcase
        end

        // Trigger: software command or rising event edge
        st_nxt.ev_d = start_event_i;
        trig = st_r.enable && ((wr_take
            && avm_req_i.address == SAR_OFS_CMD
            && avm_req_i.writedata[SAR_CMD_START])
            || (st_r.ev_en && start_event_i
            && !st_r.ev_d));

        // Prescaler runs only while the sequencer is not idle
        st_nxt.clock_divider_select = (st_r.state == SAR_IDLE || tick) ? 9'h000
            : st_r.clock_divider_select + 9'h001;

        // Conversion sequencer
        unique case (st_r.state)
            SAR_IDLE: begin
                // Triggers while busy never reach here, so none queue
                if (trig) begin
                    st_nxt.state = SAR_START;
                    st_nxt.busy = 1'b1;
                end
            end
            SAR_START: begin
                // Channels and kind latched for the whole conversion
                st_nxt.pos_act = st_r.pos_sel;
                st_nxt.neg_act = st_r.neg_sel;
                st_nxt.diff_act = st_r.diff;
                st_nxt.acc = 20'h0_0000;
                st_nxt.samp_cnt = 8'h00;
                st_nxt.phase = 10'h000;
                st_nxt.clock_divider_select = 9'h000;
                st_nxt.state = SAR_SAMPLE;
            end
            SAR_SAMPLE: begin
                // Base plus length plus delay ticks of sampling
                if (tick) begin
                    st_nxt.phase = st_r.phase + 10'h001;
                    if (st_r.phase == samp_end - 10'h001) begin
                        st_nxt.phase = 10'h000;
                        st_nxt.state = SAR_CONVERT;
                    end
                end
            end
            SAR_CONVERT: begin
                // Last tick adds the front end word to the sum
                if (tick) begin
                    st_nxt.phase = st_r.phase + 10'h001;
                    if (st_r.phase == {6'h00, SAR_CONV_TICKS - 4'h1}) begin
                        st_nxt.phase = 10'h000;
                        st_nxt.acc = sum;
                        st_nxt.result = fmt;
                        st_nxt.state = SAR_FORMAT;
                    end
                end
            end
            SAR_FORMAT: begin
                // Two cycles, then the next burst sample or completion
                st_nxt.phase = st_r.phase + 10'h001;
                if (st_r.phase == {8'h00, SAR_FORMAT_CYCLES - 2'h1}) begin
                    st_nxt.phase = 10'h000;
                    st_nxt.clock_divider_select = 9'h000;
                    st_nxt.samp_cnt = st_r.samp_cnt + 8'h01;
                    if (st_r.samp_cnt + 8'h01 == nsamp(st_r.acc_code)) begin
                        // Bursts report the sum, single samples the word
                        st_nxt.result = st_r.acc;
                        if (st_r.acc_code == 3'h0) begin
                            st_nxt.result = st_r.result;
                        end
                        st_nxt.done_flag = 1'b1;
                        st_nxt.done_evt = 1'b1;
                        if (win_hit(st_r.win_mode, st_r.acc,
                                st_r.win_lo, st_r.win_hi)) begin
                            st_nxt.win_flag = 1'b1;
                        end
                        // Free-running restarts at once
                        st_nxt.state = st_r.cont ? SAR_START
                            : SAR_IDLE;
                        st_nxt.busy = st_r.cont;
                    end else begin
                        st_nxt.state = SAR_SAMPLE;
                    end
                end
            end
            default: st_nxt.state = SAR_IDLE;
        endcase

        // Disable stops everything at once
        // A burst cut short this way never raises done
        if (!st_r.enable) begin
            st_nxt.state = SAR_IDLE;
            st_nxt.busy = 1'b0;
        end
        // Reserved count codes act as the maximum
        if (st_nxt.acc_code > SAR_ACC_MAX_CODE) begin
            st_nxt.acc_code = SAR_ACC_MAX_CODE;
        end
        st_nxt.irq = (st_nxt.done_flag && st_nxt.done_ie)
            || (st_nxt.win_flag && st_nxt.win_ie);
        // Converter clock runs only while sampling or converting, so
        // the front end sees no edge in start-up or formatting
        st_nxt.cclk = (st_nxt.state == SAR_SAMPLE
            || st_nxt.state == SAR_CONVERT)
            && (st_nxt.clock_divider_select < (div >> 1));
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            // Bus idles with waitrequest high, window top fully open
            st_r <= '0;
            st_r.state <= SAR_IDLE;
            st_r.wait_r <= 1'b1;
            st_r.win_hi <= SAR_WINHI_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    // Phase strobes are bits of the one-hot state
    assign avm_readdata_o = st_r.rdata;
    assign avm_waitrequest_o = st_r.wait_r;
    assign done_event_o = st_r.done_evt;
    assign irq_o = st_r.irq;
    assign afe_o.sample = st_r.state[2];
    assign afe_o.convert = st_r.state[3];
    assign afe_o.conv_clk = st_r.cclk;
    assign afe_o.diff = st_r.diff_act;
    assign afe_o.pos = st_r.pos_act;
    assign afe_o.neg = st_r.neg_act;
endmodule // sar_ctrl
`default_nettype wire

//--- sim/sar_afe_model.sv
// Analog front end stand-in answering a fixed code per channel setup
`default_nettype none
module sar_afe_model (
    // Front end controls and returned sample
    input wire sar_pkg::sar_afe_t afe_i,
    output logic [11:0] data_o
);
    import sar_pkg::*;
    logic [11:0] code;
    // Code from latched channels, so a stale channel shows in the result
    assign code = afe_i.diff ? {afe_i.pos, afe_i.neg}
        : {afe_i.pos, 6'h15};
    // Inverted outside the convert phase so stale samples cannot pass
    assign data_o = afe_i.convert ? code : ~code;
endmodule // sar_afe_model
`default_nettype wire

//--- sim/sar_converter_control_test.sv
// Register-level testbench for the converter control block
`default_nettype none
module sar_converter_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sar_pkg::*;
    logic core_clk_i, resetn_i, start_event_i, wreq, done_ev, irq;
    sar_avm_req_t req;
    sar_afe_t afe;
    logic [31:0] rdata, rd;
    logic [11:0] afe_data;
    int mismatches, cmp_count, ns, nc, nk, s0, c0, k0;
    logic ck_d;
    // Control words and expected results for pos 5, neg 9
    logic [31:0] cfg [8] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0005,
        32'h0000_0009, 32'h0000_000D, 32'h0000_2001, 32'h0000_2009,
        32'h0000_7001};
    logic [31:0] res [8] = '{32'h0000_0155, 32'h0000_0149, 32'h0000_0055,
        32'h0000_1550, 32'h0000_1540, 32'h0000_0554, 32'h0000_0554,
        32'h0000_AA80};
    // Windows around, above and below the 0x155 sample; hit bit per mode
    logic [15:0] wlo [3] = '{16'h0100, 16'h0200, 16'h0010};
    logic [15:0] whi [3] = '{16'h0200, 16'h0300, 16'h0100};
    logic [4:0] whit [3] = '{5'h08, 5'h12, 5'h14};

    sar_ctrl sar_ctrl_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .avm_req_i(req), .avm_readdata_o(rdata), .avm_waitrequest_o(wreq),
        .start_event_i(start_event_i), .afe_data_i(afe_data), .afe_o(afe),
        .done_event_o(done_ev), .irq_o(irq));
    sar_afe_model sar_afe_model_inst (.afe_i(afe), .data_o(afe_data));

    // Clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // Cycles spent in sample and convert phases, and converter clock rising edges
    always @(posedge core_clk_i) begin
        if (afe.sample === 1'b1) ns <= ns + 1;
        if (afe.convert === 1'b1) nc <= nc + 1;
        ck_d <= afe.conv_clk;
        if (afe.conv_clk === 1'b1 && ck_d === 1'b0) nk <= nk + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        req <= '{!wr, wr, a, wd};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        check(32'(n >= 50), 32'h0000_0000);
        rd = rdata;
        req <= '0;
        @(posedge core_clk_i);
    endtask
    task automatic wrt(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (done_ev !== 1'b1 && n < 8000);
        check(32'(n >= 8000), 32'h0000_0000);
    endtask
    task automatic pulse();
        start_event_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        start_event_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    // Software start, channel moved mid-run, then result and flags
    task automatic conv(input logic [31:0] ctrl, input logic [31:0] exp,
        input logic [1:0] st);
        wrt(SAR_OFS_MUX, 32'h0000_0905);
        wrt(SAR_OFS_CTRL, ctrl);
        wrt(SAR_OFS_CMD, 32'h0000_0001);
        rdc(SAR_OFS_CMD, 32'h0000_0001);
        wrt(SAR_OFS_MUX, 32'h0000_0907);
        wait_done();
        rdc(SAR_OFS_CMD, 32'h0000_0000);
        rdc(SAR_OFS_RESULT, exp);
        rdc(SAR_OFS_STATUS, {30'h0, st});
        check({31'h0, irq}, {31'h0, (st[0] & ctrl[16])
            | (st[1] & ctrl[17])});
        wrt(SAR_OFS_STATUS, 32'h0000_0003);
        check({31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        req = '0;
        start_event_i = 1'b0;
        resetn_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        // Reset values and an unmapped place
        rdc(SAR_OFS_CTRL, SAR_CTRL_RST);
        rdc(SAR_OFS_WINHI, {16'h0000, SAR_WINHI_RST});
        wrt(6'h3C, 32'hFFFF_FFFF);
        rdc(6'h3C, 32'h0000_0000);
        // Disabled block ignores command and events
        wrt(SAR_OFS_CTRL, 32'h0000_0020);
        wrt(SAR_OFS_CMD, 32'h0000_0001);
        pulse();
        repeat (80) @(posedge core_clk_i);
        rdc(SAR_OFS_CMD, 32'h0000_0000);
        rdc(SAR_OFS_STATUS, 32'h0000_0000);
        // Events ignored until event start is on
        wrt(SAR_OFS_MUX, 32'h0000_0905);
        wrt(SAR_OFS_CTRL, 32'h0000_0001);
        pulse();
        repeat (80) @(posedge core_clk_i);
        rdc(SAR_OFS_STATUS, 32'h0000_0000);
        wrt(SAR_OFS_CTRL, 32'h0000_0021);
        pulse();
        wait_done();
        rdc(SAR_OFS_RESULT, 32'h0000_0155);
        wrt(SAR_OFS_STATUS, 32'h0000_0003);
        // Kinds, depths, alignment and accumulation
        for (int i = 0; i < 8; i++) begin
            conv(cfg[i], res[i],
                2'b01);
        end
        // Every window mode against a value inside, below and above
        for (int w = 0; w < 3; w++) begin
            wrt(SAR_OFS_WINLO, {16'h0000, wlo[w]});
            wrt(SAR_OFS_WINHI, {16'h0000, whi[w]});
            for (int m = 0; m < 5; m++) begin
                wrt(SAR_OFS_WINCTRL, 32'(m));
                conv(32'h0002_0001, 32'h0000_0155,
                    {whit[w][m], 1'b1});
            end
        end
        wrt(SAR_OFS_WINCTRL, 32'h0000_0000);
        conv(32'h0001_0001, 32'h0000_0155, 2'b01);
        // Phase lengths follow divider, sample length and delay
        for (int k = 0; k < 2; k++) begin
            wrt(SAR_OFS_TIMING, k ? 32'h0000_0203 : 32'h0000_0000);
            s0 = ns;
            c0 = nc;
            k0 = nk;
            conv(k ? 32'h0000_0101 : 32'h0000_0001, 32'h0000_0155, 2'b01);
            check(32'(ns - s0),
                k ? 32'h0000_001C : 32'h0000_0004);
            check(32'(nc - c0), k ? 32'h0000_0038 : 32'h0000_001C);
            check(32'(nk - k0), k ? 32'h0000_0015 : 32'h0000_0010);
        end
        // Continuous mode restarts until switched off
        wrt(SAR_OFS_CTRL, 32'h0000_0011);
        wrt(SAR_OFS_CMD, 32'h0000_0001);
        wait_done();
        wait_done();
        wrt(SAR_OFS_CTRL, 32'h0000_0001);
        wait_done();
        repeat (2) @(posedge core_clk_i);
        rdc(SAR_OFS_CMD, 32'h0000_0000);
        tally_and_finish();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule // sar_converter_control_test

bind sar_ctrl sar_ctrl_checker sar_ctrl_checker_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avm_req_i(avm_req_i),
    .avm_readdata_o(avm_readdata_o), .avm_waitrequest_o(avm_waitrequest_o),
    .start_event_i(start_event_i), .afe_data_i(afe_data_i), .afe_o(afe_o),
    .done_event_o(done_event_o), .irq_o(irq_o));
`default_nettype wire

//--- sim/sar_ctrl_checker.sv
// Port-level assertions for the converter control block
`default_nettype none
module sar_ctrl_checker (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Watched ports
    input wire sar_pkg::sar_avm_req_t avm_req_i,
    input wire logic [31:0] avm_readdata_o,
    input wire logic avm_waitrequest_o,
    input wire logic start_event_i,
    input wire logic [11:0] afe_data_i,
    input wire sar_pkg::sar_afe_t afe_o,
    input wire logic done_event_o,
    input wire logic irq_o
);
    import sar_pkg::*;
    default clocking chk_cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Bus handshake shape
    wait_answer_a: assert property ((avm_req_i.read || avm_req_i.write)
        && avm_waitrequest_o |=> !avm_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    wait_single_a: assert property (!avm_waitrequest_o |=> avm_waitrequest_o)
        else $error("waitrequest low too long");
    wait_idle_a: assert property (!(avm_req_i.read || avm_req_i.write)
        && avm_waitrequest_o |=> avm_waitrequest_o)
        else $error("answer without request");
    read_hold_a: assert property (!(avm_req_i.read && avm_waitrequest_o)
        |=> $stable(avm_readdata_o))
        else $error("read data changed without read");
    // Conversion sequencing
    done_pulse_a: assert property (done_event_o |=> !done_event_o)
        else $error("completion event longer than one cycle");
    phase_excl_a: assert property (
        !(afe_o.sample && afe_o.convert))
        else $error("sample and convert together");
    convert_entry_a: assert property (
        $rose(afe_o.convert) |-> $past(afe_o.sample))
        else $error("convert began without sampling");
    done_quiet_a: assert property (done_event_o |->
        !afe_o.sample && !afe_o.convert && !afe_o.conv_clk)
        else $error("front end active at completion");
    chan_hold_a: assert property (
        afe_o.convert && $past(afe_o.convert)
        |-> $stable({afe_o.diff, afe_o.pos, afe_o.neg}))
        else $error("channel changed mid conversion");
    // Main scenarios
    cover property (done_event_o);
    cover property (irq_o);
    cover property ($rose(afe_o.convert));
endmodule // sar_ctrl_checker
`default_nettype wire
